// File: common/asq_if.sv
// link between converter sequencer and host controller
`timescale 1ns/100ps
interface asq_if;
  logic                          convert_start;
  logic                          power_down_n;
  logic                          external_clock_in;
  logic                          busy;
  logic                          conversion_done_n;
  logic                          first_result_flag;
  logic                          cs_n;
  logic                          rd_n;
  logic                          wr_n;
  logic [asq_pkg::DATA_W-1:0]    dev_data_out;
  logic                          dev_data_oe_n;
  logic [asq_pkg::DATA_W-1:0]    host_data_out;
  logic                          host_data_oe_n;
  logic [asq_pkg::DATA_W-1:0]    data_bus;
  // resolved bus level, zero when nobody drives
  assign data_bus = !dev_data_oe_n ? dev_data_out :
                    (!host_data_oe_n ? host_data_out : '0);
  modport dev (
    input  convert_start, power_down_n, external_clock_in, cs_n, rd_n, wr_n, data_bus,
    output busy, conversion_done_n, first_result_flag, dev_data_out, dev_data_oe_n
  );
  modport host (
    input  busy, conversion_done_n, first_result_flag, data_bus,
    output convert_start, power_down_n, external_clock_in, cs_n, rd_n, wr_n,
           host_data_out, host_data_oe_n
  );
endinterface : asq_if

// File: common/asq_pkg.sv
// shared constants, timing counts and state types for the sequencer link
package asq_pkg;
  localparam int CLK_NS = 50;
  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_up
  function automatic int cyc_dn(input int ns);
    return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
  endfunction : cyc_dn
  localparam int N_CH   = 4;
  localparam int DATA_W = 12;
  localparam int CFG_W  = 4;
  localparam int PTR_W  = 2;
  localparam int CNT_W  = 17;
  localparam int WORD_W = DATA_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'hf;
  // times in ns as printed
  localparam int T_CONV_INT_NS = 1650;
  localparam int T_DONE_MIN_NS = 75;
  localparam int T_DONE_MAX_NS = 180;
  localparam int T_RD_NS       = 40;
  localparam int T_RD_GAP_NS   = 10;
  localparam int T_WR_NS       = 20;
  localparam int T_WR_HOLD_NS  = 5;
  localparam int T_WAKE_EXT_NS = 2000;
  localparam int T_WAKE_INT_NS = 6000000;
  localparam int EXT_CONV_CLKS = 13;
  // derived cycle counts at 20 MHz
  localparam int CONV_INT_CYC = cyc_dn(T_CONV_INT_NS);
  localparam int DONE_CYC     = cyc_up(T_DONE_MIN_NS);
  localparam int RD_LOW_CYC   = cyc_up(T_RD_NS) + 1;
  localparam int RD_GAP_CYC   = cyc_up(T_RD_GAP_NS);
  localparam int WR_LOW_CYC   = cyc_up(T_WR_NS);
  localparam int WR_HOLD_CYC  = cyc_up(T_WR_HOLD_NS);
  localparam int WAKE_EXT_CYC = cyc_up(T_WAKE_EXT_NS);
  localparam int WAKE_INT_CYC = cyc_up(T_WAKE_INT_NS);
  localparam int EXT_DIV_HALF = 2;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_CONV = 2'b01,
    D_DONE = 2'b10
  } asq_dev_state_t;
  typedef enum logic [3:0] {
    H_SLEEP   = 4'b0000,
    H_WAKE    = 4'b0001,
    H_IDLE    = 4'b0010,
    H_START   = 4'b0011,
    H_WAIT    = 4'b0100,
    H_RD_LO   = 4'b0101,
    H_RD_HI   = 4'b0110,
    H_WR_SET  = 4'b0111,
    H_WR_LO   = 4'b1000,
    H_WR_HOLD = 4'b1001
  } asq_host_state_t;
endpackage : asq_pkg

// File: hw/asq_dev.sv
// converter sequencer end: conversion timing, result registers, parallel port
// How it works
// - external clock: thirteen clock cycles per conversion
// - internal clock: conversion within 1.65 us
// - busy spans n conversions plus the n-1 done gaps between them
// - host waits wake-up time before start
// - busy rises within 70 ns of start
// - first flag changes only on read rise or at conversion end
// - first flag low when done pulse falls
// - read strobe held low; data valid meanwhile
// - bus released 5 to 30 ns after read; here one clock (50 ns) after read rise
// - host leaves gap between reads
// - write strobe width and data setup/hold
// - write rise latches four low data bits
// - first flag set high when a read wraps pointer back to first
// - start holds samples, latches selection, converts
// - busy stays high until sequence ends
`timescale 1ns/100ps
module asq_dev (
  // clock and reset
  input  wire logic                                        clk,
  input  wire logic                                        srst,
  // link to host
  asq_if.dev                                               link,
  // analog samples and selection straps
  input  wire logic [asq_pkg::N_CH-1:0][asq_pkg::DATA_W-1:0] sample_in,
  input  wire logic                                        use_ext_clock,
  input  wire logic                                        sw_select_mode,
  input  wire logic [asq_pkg::CFG_W-1:0]                   hw_channel_sel,
  // status
  output logic [asq_pkg::CFG_W-1:0]                        channel_select
);
  // lowest selected channel
  function automatic logic [asq_pkg::PTR_W-1:0] first_ch(input logic [asq_pkg::CFG_W-1:0] s);
    logic [asq_pkg::PTR_W-1:0] r;
    r = '0;
    for (int i = asq_pkg::CFG_W - 1; i >= 0; i--) begin
      if (s[i]) begin
        r = asq_pkg::PTR_W'(i);
      end
    end
    return r;
  endfunction : first_ch

  asq_pkg::asq_dev_state_t                      state_reg, state_next;
  logic [5:0]                                   cnt_reg, cnt_next;
  logic [asq_pkg::PTR_W-1:0]                    ch_reg, ch_next;
  logic [asq_pkg::CFG_W-1:0]                    rem_reg, rem_next;
  logic [asq_pkg::CFG_W-1:0]                    cfg_reg, cfg_next;
  logic [asq_pkg::N_CH-1:0][asq_pkg::DATA_W-1:0] held_reg, held_next;
  logic [asq_pkg::N_CH-1:0][asq_pkg::DATA_W-1:0] res_reg, res_next;
  logic [2:0]                                   nres_reg, nres_next;
  logic [asq_pkg::PTR_W-1:0]                    ptr_reg, ptr_next;
  logic                                         ext_mode_reg, ext_mode_next;
  logic                                         flag_reg, flag_next;
  logic                                         busy_reg, busy_next;
  logic                                         done_n_reg, done_n_next;
  logic [asq_pkg::DATA_W-1:0]                   dout_reg, dout_next;
  logic                                         oe_n_reg, oe_n_next;
  logic                                         rd_act_reg, rd_act_next;
  logic                                         start_prev_reg, rd_prev_reg;
  logic                                         wr_prev_reg, ext_prev_reg;

  logic                                         start_rise;
  logic                                         rd_fall;
  logic                                         rd_rise;
  logic                                         wr_rise;
  logic                                         tick;
  logic [5:0]                                   limit;
  logic [asq_pkg::CFG_W-1:0]                    sel;
  logic [asq_pkg::CFG_W-1:0]                    rem_left;
  logic [2:0]                                   ptr_inc;

  assign start_rise = link.convert_start & ~start_prev_reg;
  assign rd_fall    = rd_prev_reg & ~link.rd_n & ~link.cs_n;
  assign rd_rise    = ~rd_prev_reg & link.rd_n & rd_act_reg;
  assign wr_rise    = ~wr_prev_reg & link.wr_n & ~link.cs_n & link.rd_n;
  assign tick       = ext_mode_reg ? (link.external_clock_in & ~ext_prev_reg) : 1'b1;
  assign limit      = ext_mode_reg ? 6'(asq_pkg::EXT_CONV_CLKS) : 6'(asq_pkg::CONV_INT_CYC);
  assign sel        = sw_select_mode ? cfg_reg : hw_channel_sel;
  assign rem_left   = rem_reg & ~(asq_pkg::CFG_W'(1) << ch_reg);
  assign ptr_inc    = 3'(ptr_reg) + 3'h1;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    ch_next       = ch_reg;
    rem_next      = rem_reg;
    cfg_next      = cfg_reg;
    held_next     = held_reg;
    res_next      = res_reg;
    nres_next     = nres_reg;
    ptr_next      = ptr_reg;
    ext_mode_next = ext_mode_reg;
    flag_next     = flag_reg;
    busy_next     = busy_reg;
    done_n_next   = done_n_reg;
    dout_next     = dout_reg;
    oe_n_next     = ~(~link.rd_n & ~link.cs_n);
    rd_act_next   = rd_act_reg;
    if (wr_rise) begin
      cfg_next = link.data_bus[asq_pkg::CFG_W-1:0];
    end
    if (rd_fall) begin
      dout_next   = res_reg[ptr_reg];
      rd_act_next = 1'b1;
    end
    if (rd_rise) begin
      rd_act_next = 1'b0;
      if (ptr_inc >= nres_reg) begin
        ptr_next  = '0;
        flag_next = 1'b1;
      end else begin
        ptr_next  = ptr_inc[asq_pkg::PTR_W-1:0];
        flag_next = 1'b0;
      end
    end
    unique case (state_reg)
      asq_pkg::D_IDLE: begin
        if (start_rise && link.power_down_n && sel != '0) begin
          held_next     = sample_in;
          rem_next      = sel;
          ch_next       = first_ch(sel);
          ext_mode_next = use_ext_clock;
          nres_next     = '0;
          ptr_next      = '0;
          cnt_next      = '0;
          busy_next     = 1'b1;
          state_next    = asq_pkg::D_CONV;
        end
      end
      asq_pkg::D_CONV: begin
        if (tick) begin
          if (cnt_reg == limit - 6'h1) begin
            res_next[nres_reg[asq_pkg::PTR_W-1:0]] = held_reg[ch_reg];
            nres_next   = nres_reg + 3'h1;
            rem_next    = rem_left;
            done_n_next = 1'b0;
            flag_next   = 1'b0;
            cnt_next    = '0;
            if (rem_left == '0) begin
              busy_next = 1'b0;
            end
            state_next  = asq_pkg::D_DONE;
          end else begin
            cnt_next = cnt_reg + 6'h1;
          end
        end
      end
      asq_pkg::D_DONE: begin
        if (cnt_reg == 6'(asq_pkg::DONE_CYC - 1)) begin
          done_n_next = 1'b1;
          cnt_next    = '0;
          if (rem_reg != '0) begin
            ch_next    = first_ch(rem_reg);
            state_next = asq_pkg::D_CONV;
          end else begin
            state_next = asq_pkg::D_IDLE;
          end
        end else begin
          cnt_next = cnt_reg + 6'h1;
        end
      end
      default: begin
        state_next = asq_pkg::D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg      <= asq_pkg::D_IDLE;
      cnt_reg        <= '0;
      ch_reg         <= '0;
      rem_reg        <= '0;
      cfg_reg        <= asq_pkg::CFG_RESET;
      held_reg       <= '0;
      res_reg        <= '0;
      nres_reg       <= '0;
      ptr_reg        <= '0;
      ext_mode_reg   <= 1'b0;
      flag_reg       <= 1'b1;
      busy_reg       <= 1'b0;
      done_n_reg     <= 1'b1;
      dout_reg       <= '0;
      oe_n_reg       <= 1'b1;
      rd_act_reg     <= 1'b0;
      start_prev_reg <= 1'b0;
      rd_prev_reg    <= 1'b1;
      wr_prev_reg    <= 1'b1;
      ext_prev_reg   <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      ch_reg         <= ch_next;
      rem_reg        <= rem_next;
      cfg_reg        <= cfg_next;
      held_reg       <= held_next;
      res_reg        <= res_next;
      nres_reg       <= nres_next;
      ptr_reg        <= ptr_next;
      ext_mode_reg   <= ext_mode_next;
      flag_reg       <= flag_next;
      busy_reg       <= busy_next;
      done_n_reg     <= done_n_next;
      dout_reg       <= dout_next;
      oe_n_reg       <= oe_n_next;
      rd_act_reg     <= rd_act_next;
      start_prev_reg <= link.convert_start;
      rd_prev_reg    <= link.rd_n;
      wr_prev_reg    <= link.wr_n;
      ext_prev_reg   <= link.external_clock_in;
    end
  end

  assign link.busy              = busy_reg;
  assign link.conversion_done_n = done_n_reg;
  assign link.first_result_flag = flag_reg;
  assign link.dev_data_out      = dout_reg;
  assign link.dev_data_oe_n     = oe_n_reg;
  assign channel_select         = cfg_reg;
endmodule : asq_dev

// File: hw/asq_host.sv
// host controller end: wake-up, start, register write, result reads into a fifo
`timescale 1ns/100ps
module asq_fifo #(
  parameter int WIDTH = asq_pkg::WORD_W,
  parameter int DEPTH = asq_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] mem_reg, mem_next;
  logic [AW-1:0]               wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]                 cnt_reg, cnt_next;
  logic                        push, pop;

  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + AW'(1);
    end
    if (pop) begin
      rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + AW'(1);
    end
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_reg <= '0;
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : asq_fifo

module asq_host #(
  parameter int WAKE_INT_CYC = asq_pkg::WAKE_INT_CYC
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         srst,
  // link to converter
  asq_if.host                               link,
  // commands
  input  wire logic                         awake,
  input  wire logic                         use_int_ref,
  input  wire logic                         start_req,
  input  wire logic                         cfg_valid,
  input  wire logic [asq_pkg::CFG_W-1:0]    cfg_data,
  output logic                              cmd_ready,
  // results, flag bit above data
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [asq_pkg::WORD_W-1:0]        out_data
);
  asq_pkg::asq_host_state_t   state_reg, state_next;
  logic [asq_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic [2:0]                 nrd_reg, nrd_next;
  logic                       seen_busy_reg, seen_busy_next;
  logic                       done_prev_reg;
  logic                       pd_n_reg, cs_n_reg, rd_n_reg, wr_n_reg, start_reg;
  logic                       hoe_n_reg;
  logic [asq_pkg::CFG_W-1:0]  hdat_reg, hdat_next;
  logic [1:0]                 div_reg;
  logic                       eclk_reg;
  logic                       push;
  logic                       fifo_ready;
  logic [asq_pkg::CNT_W-1:0]  wake_last;

  assign wake_last = use_int_ref ? asq_pkg::CNT_W'(WAKE_INT_CYC - 1)
                                 : asq_pkg::CNT_W'(asq_pkg::WAKE_EXT_CYC - 1);
  assign push = (state_reg == asq_pkg::H_RD_LO) &&
                (cnt_reg == asq_pkg::CNT_W'(asq_pkg::RD_LOW_CYC - 1));

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg + asq_pkg::CNT_W'(1);
    nrd_next       = nrd_reg;
    seen_busy_next = seen_busy_reg;
    hdat_next      = hdat_reg;
    unique case (state_reg)
      asq_pkg::H_SLEEP: begin
        cnt_next = '0;
        if (awake) begin
          state_next = asq_pkg::H_WAKE;
        end
      end
      asq_pkg::H_WAKE: begin
        if (cnt_reg == wake_last) begin
          state_next = asq_pkg::H_IDLE;
        end
      end
      asq_pkg::H_IDLE: begin
        cnt_next = '0;
        if (cfg_valid) begin
          hdat_next  = cfg_data;
          state_next = asq_pkg::H_WR_SET;
        end else if (start_req) begin
          nrd_next       = '0;
          seen_busy_next = 1'b0;
          state_next     = asq_pkg::H_START;
        end
      end
      asq_pkg::H_START: begin
        cnt_next   = '0;
        state_next = asq_pkg::H_WAIT;
      end
      asq_pkg::H_WAIT: begin
        cnt_next = '0;
        if (done_prev_reg && !link.conversion_done_n) begin
          nrd_next = nrd_reg + 3'h1;
        end
        if (link.busy) begin
          seen_busy_next = 1'b1;
        end else if (seen_busy_reg && nrd_reg != '0 && fifo_ready) begin
          state_next = asq_pkg::H_RD_LO;
        end
      end
      asq_pkg::H_RD_LO: begin
        if (push) begin
          cnt_next   = '0;
          nrd_next   = nrd_reg - 3'h1;
          state_next = asq_pkg::H_RD_HI;
        end
      end
      asq_pkg::H_RD_HI: begin
        if (cnt_reg >= asq_pkg::CNT_W'(asq_pkg::RD_GAP_CYC - 1)) begin
          cnt_next = '0;
          if (nrd_reg == '0) begin
            state_next = asq_pkg::H_IDLE;
          end else if (fifo_ready) begin
            state_next = asq_pkg::H_RD_LO;
          end
        end
      end
      asq_pkg::H_WR_SET: begin
        cnt_next   = '0;
        state_next = asq_pkg::H_WR_LO;
      end
      asq_pkg::H_WR_LO: begin
        if (cnt_reg == asq_pkg::CNT_W'(asq_pkg::WR_LOW_CYC - 1)) begin
          cnt_next   = '0;
          state_next = asq_pkg::H_WR_HOLD;
        end
      end
      asq_pkg::H_WR_HOLD: begin
        if (cnt_reg == asq_pkg::CNT_W'(asq_pkg::WR_HOLD_CYC - 1)) begin
          state_next = asq_pkg::H_IDLE;
        end
      end
      default: begin
        state_next = asq_pkg::H_SLEEP;
      end
    endcase
    if (!awake) begin
      state_next = asq_pkg::H_SLEEP;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= asq_pkg::H_SLEEP;
      cnt_reg       <= '0;
      nrd_reg       <= '0;
      seen_busy_reg <= 1'b0;
      hdat_reg      <= '0;
      done_prev_reg <= 1'b1;
      pd_n_reg      <= 1'b0;
      cs_n_reg      <= 1'b1;
      rd_n_reg      <= 1'b1;
      wr_n_reg      <= 1'b1;
      start_reg     <= 1'b0;
      hoe_n_reg     <= 1'b1;
      div_reg       <= '0;
      eclk_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      nrd_reg       <= nrd_next;
      seen_busy_reg <= seen_busy_next;
      hdat_reg      <= hdat_next;
      done_prev_reg <= link.conversion_done_n;
      pd_n_reg      <= state_next != asq_pkg::H_SLEEP;
      cs_n_reg      <= !(state_next inside {asq_pkg::H_RD_LO, asq_pkg::H_WR_SET,
                                            asq_pkg::H_WR_LO, asq_pkg::H_WR_HOLD});
      rd_n_reg      <= state_next != asq_pkg::H_RD_LO;
      wr_n_reg      <= state_next != asq_pkg::H_WR_LO;
      start_reg     <= state_next == asq_pkg::H_START;
      hoe_n_reg     <= !(state_next inside {asq_pkg::H_WR_SET, asq_pkg::H_WR_LO,
                                             asq_pkg::H_WR_HOLD});
      // free-running 5 MHz conversion clock
      if (div_reg == 2'(asq_pkg::EXT_DIV_HALF - 1)) begin
        div_reg  <= '0;
        eclk_reg <= ~eclk_reg;
      end else begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end

  asq_fifo #(
    .WIDTH (asq_pkg::WORD_W),
    .DEPTH (asq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({link.first_result_flag, link.data_bus}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  assign cmd_ready              = state_reg == asq_pkg::H_IDLE;
  assign link.power_down_n      = pd_n_reg;
  assign link.convert_start     = start_reg;
  assign link.external_clock_in = eclk_reg;
  assign link.cs_n              = cs_n_reg;
  assign link.rd_n              = rd_n_reg;
  assign link.wr_n              = wr_n_reg;
  assign link.host_data_out     = {(asq_pkg::DATA_W - asq_pkg::CFG_W)'(0), hdat_reg};
  assign link.host_data_oe_n    = hoe_n_reg;
endmodule : asq_host

// File: tb/asq_properties.sv
// concurrent checks on the converter to host link
`timescale 1ns/100ps
module asq_properties #(
  parameter int WAKE_CYC = 40
) (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       srst,
  // link signals
  input wire logic                       convert_start,
  input wire logic                       power_down_n,
  input wire logic                       busy,
  input wire logic                       conversion_done_n,
  input wire logic                       first_result_flag,
  input wire logic                       cs_n,
  input wire logic                       rd_n,
  input wire logic                       wr_n,
  input wire logic                       dev_data_oe_n,
  input wire logic                       host_data_oe_n,
  input wire logic [asq_pkg::DATA_W-1:0] host_data_out
);
  logic [7:0] wake_reg, wake_next;
  logic [2:0] rdh_reg, rdh_next;
  logic       rdn_reg, rdn_next;
  // cycles since leaving standby, recent read rises
  always_comb begin
    wake_next = (srst || !power_down_n) ? 8'h00 : wake_reg + 8'(wake_reg != 8'hff);
    rdh_next  = srst ? 3'h0 : {rdh_reg[1:0], rd_n & !rdn_reg};
    rdn_next  = srst ? 1'b1 : rd_n;
  end
  always_ff @(posedge clk) begin
    wake_reg <= wake_next;
    rdh_reg  <= rdh_next;
    rdn_reg  <= rdn_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_done_rest; !conversion_done_n ##1 conversion_done_n; endsequence
  sequence s_release; !dev_data_oe_n ##[1:2] dev_data_oe_n; endsequence
  property p_busy_rise; $rose(convert_start) && !busy |=> busy; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late");
  property p_done_width; $fell(conversion_done_n) |=> s_done_rest; endproperty
  a_done_width: assert property (p_done_width) else $error("done width");
  property p_flag_done; $fell(conversion_done_n) |-> !first_result_flag; endproperty
  a_flag_done: assert property (p_flag_done) else $error("flag not low");
  property p_flag_cause; $changed(first_result_flag) |-> (|rdh_reg) || !conversion_done_n;
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag moved");
  property p_busy_end; $fell(busy) |-> $fell(conversion_done_n); endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy end");
  property p_rd_data; $fell(rd_n) && !cs_n |-> ##[1:2] !dev_data_oe_n; endproperty
  a_rd_data: assert property (p_rd_data) else $error("no read data");
  property p_rd_release; $rose(rd_n) |-> s_release; endproperty
  a_rd_release: assert property (p_rd_release) else $error("bus release");
  property p_rd_gap; $fell(rd_n) |-> $past(cs_n); endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read gap");
  property p_wr_hold; $rose(wr_n) |-> !cs_n && !host_data_oe_n && $stable(host_data_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data");
  property p_wake; $rose(convert_start) |-> wake_reg >= WAKE_CYC; endproperty
  a_wake: assert property (p_wake) else $error("start too early");
endmodule : asq_properties

// File: tb/testbench.sv
// self-checking bench: host controller and converter sequencer on one link
`timescale 1ns/100ps
module testbench;
  localparam int SPAN = asq_pkg::CONV_INT_CYC + asq_pkg::DONE_CYC;
  logic                                          clk = 1'b0;
  logic                                          srst = 1'b1;
  logic [asq_pkg::N_CH-1:0][asq_pkg::DATA_W-1:0] sample_in;
  logic use_ext_clock = 1'b0, sw_select_mode = 1'b1, awake = 1'b0, use_int_ref = 1'b0;
  logic start_req = 1'b0, cfg_valid = 1'b0, out_ready = 1'b0, cmd_ready, out_valid;
  logic [asq_pkg::CFG_W-1:0]                     hw_channel_sel = 4'h0, cfg_data = 4'h0;
  logic [asq_pkg::CFG_W-1:0]                     channel_select;
  logic [asq_pkg::WORD_W-1:0]                    out_data;
  int                                            num_errors = 0, compares = 0;
  always #25 clk = ~clk;
  asq_if i_asq_if ();
  asq_dev i_asq_dev (.clk(clk), .srst(srst), .link(i_asq_if.dev), .sample_in(sample_in),
    .use_ext_clock(use_ext_clock), .sw_select_mode(sw_select_mode),
    .hw_channel_sel(hw_channel_sel), .channel_select(channel_select));
  asq_host #(.WAKE_INT_CYC(20)) i_asq_host (.clk(clk), .srst(srst), .link(i_asq_if.host),
    .awake(awake), .use_int_ref(use_int_ref), .start_req(start_req), .cfg_valid(cfg_valid),
    .cfg_data(cfg_data), .cmd_ready(cmd_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  asq_properties #(.WAKE_CYC(asq_pkg::WAKE_EXT_CYC)) i_asq_properties (.clk(clk),
    .srst(srst), .convert_start(i_asq_if.convert_start), .power_down_n(i_asq_if.power_down_n),
    .busy(i_asq_if.busy), .conversion_done_n(i_asq_if.conversion_done_n),
    .first_result_flag(i_asq_if.first_result_flag), .cs_n(i_asq_if.cs_n),
    .rd_n(i_asq_if.rd_n), .wr_n(i_asq_if.wr_n), .dev_data_oe_n(i_asq_if.dev_data_oe_n),
    .host_data_oe_n(i_asq_if.host_data_oe_n), .host_data_out(i_asq_if.host_data_out));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(16'(n < 3000), 16'h1);
  endtask : wait_ready
  task automatic write_cfg(input logic [3:0] v);
    wait_ready();
    cfg_data = v;
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    wait_ready();
    check(16'(channel_select), 16'(v));
  endtask : write_cfg
  // start a sequence, selection changes once busy is seen, busy length counted
  task automatic run_seq(input logic [3:0] sel, input int lo, input int hi);
    int nb;
    nb = 0;
    wait_ready();
    hw_channel_sel = sel;
    start_req = 1'b1;
    @(negedge clk);
    start_req = 1'b0;
    for (int k = 0; k < 4000 && (nb == 0 || i_asq_if.busy !== 1'b0); k++) begin
      @(negedge clk);
      nb += int'(i_asq_if.busy === 1'b1);
      if (nb == 1) hw_channel_sel = ~sel;
    end
    check(16'(nb >= lo && nb <= hi), 16'h1);
  endtask : run_seq
  task automatic drain(input logic [3:0] sel, input int reps);
    int k;
    @(negedge clk);
    out_ready = 1'b1;
    for (int r = 0; r < reps; r++)
      for (int c = 0; c < 4; c++)
        if (sel[c]) begin
          k = 0;
          while (out_valid !== 1'b1 && k < 500) begin
            @(negedge clk);
            k++;
          end
          check(16'({out_valid, out_data[11:0]}), 16'({1'b1, sample_in[c]}));
          @(negedge clk);
        end
    out_ready = 1'b0;
  endtask : drain
  initial begin
    #(60000 * 50);
    num_errors++;
    final_report();
  end
  initial begin
    for (int c = 0; c < 4; c++) sample_in[c] = 12'h3a0 + 12'(c * 12'h111);
    repeat (10) @(negedge clk);
    srst = 1'b0;
    check(16'({i_asq_if.busy, i_asq_if.first_result_flag, channel_select}), 16'h1f);
    awake = 1'b1;
    write_cfg(4'h5);
    run_seq(4'h5, 2 * SPAN - 2, 2 * SPAN - 2);
    drain(4'h5, 1);
    write_cfg(4'h8);
    use_ext_clock = 1'b1;
    run_seq(4'h8, 48, 54);
    drain(4'h8, 1);
    use_ext_clock = 1'b0;
    sw_select_mode = 1'b0;
    run_seq(4'h2, SPAN - 2, SPAN - 2);
    drain(4'h2, 1);
    sw_select_mode = 1'b1;
    write_cfg(4'hf);
    run_seq(4'hf, 4 * SPAN - 2, 4 * SPAN - 2);
    run_seq(4'hf, 4 * SPAN - 2, 4 * SPAN - 2);
    write_cfg(4'h1);
    run_seq(4'h1, SPAN - 2, SPAN - 2);
    repeat (100) @(negedge clk);
    check(16'({cmd_ready, out_valid}), 16'h1);
    drain(4'hf, 2);
    drain(4'h1, 1);
    wait_ready();
    check(16'(i_asq_if.first_result_flag), 16'h1);
    final_report();
  end
endmodule : testbench
